// ---- hdl/mpm_pin_mux.sv ----
// multifunction pin mux with an axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - oe clear makes pin a control input
// - 7-bit code selects function, 0x00 idle/low
// - function registers at 0x0102 through 0x0108
// - combine codes held in 0x100 and 0x101
// - 00 ands level, 01 ands inverted level
// - 10 ors level, 11 ors inverted level
// - or terms evaluated before and terms
// - or group result anded with and terms
// - lone pin, 00/10 pass level directly
// - lone pin, 01/11 pass inverted level
// - 0x01 drives config update, status high
// - 0x02 drives power down, status core clock
// - 0x03 drives watchdog clear, status timeout
// - 0x04 control drives sync all
// - 0x04 status gives calibration in progress
// - 0x05 lock detect, 0x06 stable flag
// - 0x07 high when both loops locked
// - 0x08 first loop, 0x09 second loop
// - 0x0a eeprom save, 0x0b eeprom load
// - oe set drives pin with status
// - new function waits for config update
module mpm_pin_mux (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] multi_pin_in,
    output logic [6:0] multi_pin_out,
    output logic [6:0] multi_pin_oe,
    input wire mpm_pkg::mpm_status_t status_in,
    output mpm_pkg::mpm_ctrl_t ctrl_out
);

    mpm_pkg::mpm_state_t state_reg;
    mpm_pkg::mpm_state_t state_next;

    // combine code of one pin from the two packed combine registers
    function automatic logic [1:0] comb_of(input logic [1:0][7:0] comb, input int pin);
        logic [15:0] flat;
        flat = {comb[1], comb[0]};
        comb_of = flat[2*pin +: 2];
    endfunction

    // register index for a byte address
    function automatic logic [13:0] idx_of(input logic [15:0] addr);
        idx_of = addr[mpm_pkg::ADDR_W-1:mpm_pkg::IDX_LSB];
    endfunction

    // true when an index is one of the seven function registers
    function automatic logic is_func(input logic [13:0] idx);
        is_func = (idx >= mpm_pkg::IDX_FUNC_FIRST) && (idx <= mpm_pkg::IDX_FUNC_LAST);
    endfunction

    // combined control value per control function code 1..4
    logic [mpm_pkg::NUM_CTRL-1:0] ctrl_value;
    logic [mpm_pkg::NUM_CTRL-1:0] ctrl_used;
    logic [mpm_pkg::NUM_PINS-1:0] status_value;

    genvar f;
    generate
        for (f = 0; f < mpm_pkg::NUM_CTRL; f++) begin : g_ctrl
            logic [mpm_pkg::NUM_PINS-1:0] member;
            logic [mpm_pkg::NUM_PINS-1:0] or_type;
            logic [mpm_pkg::NUM_PINS-1:0] term;
            logic [mpm_pkg::NUM_PINS-1:0][1:0] cb;
            logic or_any;
            logic or_val;
            logic and_val;
            always_comb begin
                for (int p = 0; p < mpm_pkg::NUM_PINS; p++) begin
                    // oe clear and matching code makes the pin a control source
                    member[p] = !state_reg.func_active[p][mpm_pkg::FUNC_OE_BIT]
                        && (state_reg.func_active[p][mpm_pkg::FUNC_CODE_MSB:0]
                        == 7'(f + 1));
                    cb[p] = comb_of(state_reg.comb_active, p);
                    or_type[p] = cb[p][mpm_pkg::COMB_OR_BIT];
                    // invert first when the low code bit is set
                    term[p] = multi_pin_in[p] ^ cb[p][mpm_pkg::COMB_INVERT_BIT];
                end
                or_any = |(member & or_type);
                or_val = |(member & or_type & term);
                and_val = &(~(member & ~or_type) | term);
                // or group first, then anded with the and terms
                ctrl_value[f] = (or_any ? or_val : 1'b1) & and_val;
                ctrl_used[f] = |member;
            end
        end
    endgenerate

    // status source selection per pin
    genvar s;
    generate
        for (s = 0; s < mpm_pkg::NUM_PINS; s++) begin : g_stat
            logic [6:0] code;
            assign code = state_reg.func_active[s][mpm_pkg::FUNC_CODE_MSB:0];
            always_comb begin
                unique case (code)
                    mpm_pkg::CODE_NO_ACTION: status_value[s] = 1'b0;
                    mpm_pkg::CODE_CONFIG_UPDATE: status_value[s] = 1'b1;
                    mpm_pkg::CODE_POWER_DOWN: status_value[s] = ~state_reg.core_clk_div;
                    mpm_pkg::CODE_WATCHDOG: status_value[s] = status_in.watchdog_timeout;
                    mpm_pkg::CODE_SYNC_CAL: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::SCS_CAL_BIT];
                    mpm_pkg::CODE_SCS_LOCK: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::SCS_LOCK_BIT];
                    mpm_pkg::CODE_SCS_STABLE: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::SCS_STABLE_BIT];
                    mpm_pkg::CODE_BOTH_LOCKED: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::FIRST_LOOP_BIT]
                        & status_in.system_clock_source_status[mpm_pkg::SECOND_LOOP_BIT];
                    mpm_pkg::CODE_FIRST_LOOP: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::FIRST_LOOP_BIT];
                    mpm_pkg::CODE_SECOND_LOOP: status_value[s] =
                        status_in.system_clock_source_status[mpm_pkg::SECOND_LOOP_BIT];
                    mpm_pkg::CODE_EE_SAVE: status_value[s] =
                        status_in.eeprom_status[mpm_pkg::EE_SAVE_BIT];
                    mpm_pkg::CODE_EE_LOAD: status_value[s] =
                        status_in.eeprom_status[mpm_pkg::EE_LOAD_BIT];
                    default: status_value[s] = 1'b0;
                endcase
            end
        end
    endgenerate

    // bus decode
    logic [13:0] wr_idx;
    logic [13:0] rd_idx;
    logic wr_fire;
    logic rd_fire;
    logic wr_mapped;
    logic rd_mapped;
    logic sw_update;
    logic pin_update;
    logic update_event;
    logic func_write;
    logic [31:0] rd_word;

    always_comb begin
        wr_idx = idx_of(s_axi_awaddr);
        rd_idx = idx_of(s_axi_araddr);
        wr_fire = s_axi_awvalid && s_axi_wvalid && !state_reg.awready && !state_reg.bvalid;
        rd_fire = s_axi_arvalid && !state_reg.arready && !state_reg.rvalid;
        wr_mapped = is_func(wr_idx) || (wr_idx == mpm_pkg::IDX_COMBINE_LOW)
            || (wr_idx == mpm_pkg::IDX_COMBINE_HIGH) || (wr_idx == mpm_pkg::IDX_CONFIG_UPDATE)
            || (wr_idx == mpm_pkg::IDX_PIN_STATE);
        rd_mapped = is_func(rd_idx) || (rd_idx == mpm_pkg::IDX_COMBINE_LOW)
            || (rd_idx == mpm_pkg::IDX_COMBINE_HIGH) || (rd_idx == mpm_pkg::IDX_CONFIG_UPDATE)
            || (rd_idx == mpm_pkg::IDX_PIN_STATE);
        sw_update = wr_fire && s_axi_wstrb[0] && (wr_idx == mpm_pkg::IDX_CONFIG_UPDATE)
            && s_axi_wdata[mpm_pkg::CONFIG_UPDATE_BIT];
        // a pin driving the update function acts on its rising level
        pin_update = ctrl_used[0] && ctrl_value[0] && !state_reg.update_level_prev;
        update_event = sw_update || pin_update;
        func_write = wr_fire && s_axi_wstrb[0] && is_func(wr_idx);
        rd_word = 32'h0000_0000;
        if (is_func(rd_idx)) begin
            rd_word[7:0] = state_reg.func_shadow[3'(rd_idx - mpm_pkg::IDX_FUNC_FIRST)];
        end else if (rd_idx == mpm_pkg::IDX_COMBINE_LOW) begin
            rd_word[7:0] = state_reg.comb_shadow[0];
        end else if (rd_idx == mpm_pkg::IDX_COMBINE_HIGH) begin
            rd_word[7:0] = state_reg.comb_shadow[1];
        end else if (rd_idx == mpm_pkg::IDX_PIN_STATE) begin
            rd_word[6:0] = multi_pin_in;
            rd_word[11:8] = state_reg.ctrl_out;
            rd_word[12] = state_reg.hold;
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.core_clk_div = ~state_reg.core_clk_div;
        state_next.update_level_prev = ctrl_used[0] && ctrl_value[0];
        state_next.awready = wr_fire;
        state_next.wready = wr_fire;
        state_next.arready = rd_fire;
        // write side
        if (wr_fire) begin
            state_next.bvalid = 1'b1;
            state_next.bresp = wr_mapped ? mpm_pkg::RESP_OKAY : mpm_pkg::RESP_DECERR;
            if (s_axi_wstrb[0]) begin
                if (is_func(wr_idx)) begin
                    state_next.func_shadow[3'(wr_idx - mpm_pkg::IDX_FUNC_FIRST)] =
                        s_axi_wdata[7:0];
                end else if (wr_idx == mpm_pkg::IDX_COMBINE_LOW) begin
                    state_next.comb_shadow[0] = s_axi_wdata[7:0];
                end else if (wr_idx == mpm_pkg::IDX_COMBINE_HIGH) begin
                    state_next.comb_shadow[1] = s_axi_wdata[7:0];
                end
            end
        end else if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        // read side
        if (rd_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rd_word;
            state_next.rresp = rd_mapped ? mpm_pkg::RESP_OKAY : mpm_pkg::RESP_DECERR;
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        // control values freeze after a function write until the update
        if (update_event) begin
            state_next.func_active = state_reg.func_shadow;
            state_next.comb_active = state_reg.comb_shadow;
            state_next.hold = 1'b0;
        end else if (func_write) begin
            state_next.hold = 1'b1;
        end
        if (!state_reg.hold) begin
            state_next.ctrl_level = ctrl_value & ctrl_used;
        end
        state_next.ctrl_out.config_update = update_event;
        state_next.ctrl_out.power_down = state_next.ctrl_level[1];
        state_next.ctrl_out.watchdog_clear = state_next.ctrl_level[2];
        state_next.ctrl_out.sync_all = state_next.ctrl_level[3];
        // pins with oe set carry their status source
        for (int p = 0; p < mpm_pkg::NUM_PINS; p++) begin
            state_next.pin_oe[p] = state_reg.func_active[p][mpm_pkg::FUNC_OE_BIT];
            state_next.pin_out[p] = state_next.pin_oe[p] & status_value[p];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.func_shadow <= {mpm_pkg::NUM_PINS{mpm_pkg::FUNC_RESET}};
            state_reg.func_active <= {mpm_pkg::NUM_PINS{mpm_pkg::FUNC_RESET}};
            state_reg.comb_shadow <= {2{mpm_pkg::COMBINE_RESET}};
            state_reg.comb_active <= {2{mpm_pkg::COMBINE_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign multi_pin_out = state_reg.pin_out;
    assign multi_pin_oe = state_reg.pin_oe;
    assign ctrl_out = state_reg.ctrl_out;

endmodule // mpm_pin_mux

`default_nettype wire

// ---- hdl/mpm_pkg.sv ----
// package for the multifunction pin control and status mux
package mpm_pkg;
    localparam int NUM_PINS = 7;
    localparam int NUM_CTRL = 4;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CONFIG_UPDATE = 14'h000f;
    localparam logic [13:0] IDX_COMBINE_LOW = 14'h0100;
    localparam logic [13:0] IDX_COMBINE_HIGH = 14'h0101;
    localparam logic [13:0] IDX_FUNC_FIRST = 14'h0102;
    localparam logic [13:0] IDX_FUNC_LAST = 14'h0108;
    localparam logic [13:0] IDX_PIN_STATE = 14'h0110;
    localparam int ADDR_W = 16;
    localparam int IDX_LSB = 2;
    // function register fields
    localparam int FUNC_OE_BIT = 7;
    localparam int FUNC_CODE_MSB = 6;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    localparam logic [7:0] COMBINE_RESET = 8'h00;
    localparam int COMBINE_PINS_LOW = 4;
    localparam int CONFIG_UPDATE_BIT = 0;
    localparam int COMB_INVERT_BIT = 0;
    localparam int COMB_OR_BIT = 1;
    // function codes
    localparam logic [6:0] CODE_NO_ACTION = 7'h00;
    localparam logic [6:0] CODE_CONFIG_UPDATE = 7'h01;
    localparam logic [6:0] CODE_POWER_DOWN = 7'h02;
    localparam logic [6:0] CODE_WATCHDOG = 7'h03;
    localparam logic [6:0] CODE_SYNC_CAL = 7'h04;
    localparam logic [6:0] CODE_SCS_LOCK = 7'h05;
    localparam logic [6:0] CODE_SCS_STABLE = 7'h06;
    localparam logic [6:0] CODE_BOTH_LOCKED = 7'h07;
    localparam logic [6:0] CODE_FIRST_LOOP = 7'h08;
    localparam logic [6:0] CODE_SECOND_LOOP = 7'h09;
    localparam logic [6:0] CODE_EE_SAVE = 7'h0a;
    localparam logic [6:0] CODE_EE_LOAD = 7'h0b;
    // status source bit positions
    localparam int SCS_LOCK_BIT = 0;
    localparam int SCS_STABLE_BIT = 1;
    localparam int SCS_CAL_BIT = 2;
    localparam int FIRST_LOOP_BIT = 4;
    localparam int SECOND_LOOP_BIT = 5;
    localparam int EE_SAVE_BIT = 0;
    localparam int EE_LOAD_BIT = 1;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic [7:0] system_clock_source_status;
        logic [7:0] eeprom_status;
        logic watchdog_timeout;
    } mpm_status_t;

    typedef struct packed {
        logic config_update;
        logic power_down;
        logic watchdog_clear;
        logic sync_all;
    } mpm_ctrl_t;

    typedef struct packed {
        logic [1:0][7:0] comb_shadow;
        logic [NUM_PINS-1:0][7:0] func_shadow;
        logic [1:0][7:0] comb_active;
        logic [NUM_PINS-1:0][7:0] func_active;
        logic [NUM_CTRL-1:0] ctrl_level;
        logic update_level_prev;
        logic hold;
        mpm_ctrl_t ctrl_out;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic core_clk_div;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mpm_state_t;
endpackage

// ---- verification/mpm_board.sv ----
// board logic that drives and samples the multifunction pins
`timescale 1ns/10ps
`default_nettype none
module mpm_board (
    input wire logic [6:0] dev_out,
    input wire logic [6:0] dev_oe,
    input wire logic [6:0] drv,
    input wire logic [6:0] drv_en,
    output logic [6:0] level
);
    // a pin nobody drives falls to its pull-down
    always_comb level = (dev_oe & dev_out) | (~dev_oe & drv_en & drv);
endmodule // mpm_board
`default_nettype wire

// ---- verification/mpm_properties.sv ----
// checker for the pin mux ports
`timescale 1ns/10ps
`default_nettype none
module mpm_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [6:0] multi_pin_out,
    input wire logic [6:0] multi_pin_oe,
    input wire mpm_pkg::mpm_ctrl_t ctrl_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_out_needs_oe: assert property ((multi_pin_out & ~multi_pin_oe) == 7'h00)
        else $error("released pin driven high");
    a_reset_idle: assert property ($past(sys_rst) |-> multi_pin_oe == 7'h00
        && ctrl_out == 4'h0) else $error("outputs not idle after reset");
    a_oe_on_update: assert property ($changed(multi_pin_oe) |-> $past(sys_rst)
        || $past(s_axi_awready, 2) || $past(s_axi_awready, 3) || $past(ctrl_out.config_update)
        || $past(ctrl_out.config_update, 2) || $past(ctrl_out.config_update, 3))
        else $error("pin direction changed without update");
    a_cfg_pulse: assert property (ctrl_out.config_update |=> !ctrl_out.config_update)
        else $error("update pulse longer than one cycle");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_decerr_read: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        && s_axi_araddr[15:2] > mpm_pkg::IDX_PIN_STATE |=> s_axi_rresp == mpm_pkg::RESP_DECERR)
        else $error("unmapped read not refused");
    a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h00000)
        else $error("read data wider than register");
endmodule // mpm_properties
bind mpm_pin_mux mpm_properties i_mpm_properties (.mclk, .sys_rst, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .multi_pin_out, .multi_pin_oe, .ctrl_out);
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the multifunction pin mux
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    typedef struct packed {
        logic [6:0] code; logic [7:0] sc; logic [7:0] ee; logic wd; logic x;
    } mpm_row_t;
    logic mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [6:0] multi_pin_in, multi_pin_out, multi_pin_oe, drv, drv_en, prev;
    logic [3:0] k;
    mpm_pkg::mpm_status_t status_in;
    mpm_pkg::mpm_ctrl_t ctrl_out;
    int n_fail, num_checks, p, cnt;
    logic [7:0] fn [7] = '{8'h03, 8'h04, 8'h03, 8'h03, 8'h05, 8'h00, 8'h03};
    mpm_row_t rows [17] = '{'{7'h00, 8'hff, 8'hff, 1, 0}, '{7'h01, 8'h00, 8'h00, 0, 1},
        '{7'h03, 8'h00, 8'h00, 1, 1}, '{7'h03, 8'hff, 8'hff, 0, 0}, '{7'h04, 8'h04, 8'h00, 0, 1},
        '{7'h04, 8'hfb, 8'hff, 1, 0}, '{7'h05, 8'h01, 8'h00, 0, 1}, '{7'h05, 8'hfe, 8'hff, 1, 0},
        '{7'h06, 8'h02, 8'h00, 0, 1}, '{7'h07, 8'h30, 8'h00, 0, 1}, '{7'h07, 8'h10, 8'h00, 0, 0},
        '{7'h08, 8'h10, 8'h00, 0, 1}, '{7'h09, 8'h20, 8'h00, 0, 1}, '{7'h09, 8'h10, 8'hff, 1, 0},
        '{7'h0a, 8'h00, 8'h01, 0, 1}, '{7'h0b, 8'h00, 8'h02, 0, 1}, '{7'h0b, 8'hff, 8'h01, 1, 0}};
    mpm_pin_mux i_mpm_pin_mux (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .multi_pin_in, .multi_pin_out, .multi_pin_oe, .status_in,
        .ctrl_out);
    mpm_board i_mpm_board (.dev_out(multi_pin_out), .dev_oe(multi_pin_oe), .drv, .drv_en,
        .level(multi_pin_in));
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdr(input logic [13:0] idx);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic upd();
        wr(mpm_pkg::IDX_CONFIG_UPDATE, 8'h01);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hf;
        {drv, drv_en, status_in} = 31'h0;
        sys_rst = 1'b1;
        tk(6);
        sys_rst <= 1'b0;
        tk(1);
        rdr(mpm_pkg::IDX_FUNC_LAST);
        `CHK(rd, 32'h00000000)
        rdr(mpm_pkg::IDX_COMBINE_HIGH);
        `CHK(rd, 32'h00000000)
        rdr(14'h0200);
        `CHK(rr, mpm_pkg::RESP_DECERR)
        $display("register test done");
        foreach (rows[i]) begin
            p = i % 7;
            status_in <= '{rows[i].sc, rows[i].ee, rows[i].wd};
            wr(mpm_pkg::IDX_FUNC_FIRST + 14'(p), {1'b1, rows[i].code});
            upd();
            tk(3);
            `CHK(multi_pin_oe[p], 1'b1)
            `CHK(multi_pin_out[p], rows[i].x)
        end
        wr(mpm_pkg::IDX_FUNC_LAST, 8'h82);
        upd();
        tk(3);
        prev = multi_pin_out;
        tk(1);
        `CHK(multi_pin_out[6], ~prev[6])
        $display("status table done");
        for (int i = 0; i < 7; i++) wr(mpm_pkg::IDX_FUNC_FIRST + 14'(i), i == 0 ? 8'h02 : 8'h00);
        upd();
        drv_en <= 7'h7f;
        for (int c = 0; c < 4; c++) begin
            wr(mpm_pkg::IDX_COMBINE_LOW, 8'(c));
            upd();
            for (int v = 0; v < 2; v++) begin
                drv <= 7'(v);
                tk(3);
                `CHK(ctrl_out.power_down, 1'(v ^ c))
            end
        end
        foreach (fn[i]) wr(mpm_pkg::IDX_FUNC_FIRST + 14'(i), fn[i]);
        wr(mpm_pkg::IDX_COMBINE_LOW, 8'h70);
        wr(mpm_pkg::IDX_COMBINE_HIGH, 8'h20);
        upd();
        for (int j = 0; j < 16; j++) begin
            k = 4'(j);
            drv <= {k[3], k[2], k[1] ^ k[3], k[2], k[1], k[0], k[0]};
            tk(3);
            `CHK(ctrl_out.watchdog_clear, (!k[1] || k[3]) && k[0] && !k[2])
            `CHK(ctrl_out.sync_all, k[0])
            `CHK(ctrl_out.power_down, 1'b0)
        end
        drv <= 7'h03;
        tk(3);
        wr(mpm_pkg::IDX_FUNC_FIRST + 14'h1, 8'h81);
        drv <= 7'h00;
        tk(3);
        `CHK(ctrl_out.sync_all, 1'b1)
        `CHK(multi_pin_oe[1], 1'b0)
        rdr(mpm_pkg::IDX_FUNC_FIRST + 14'h1);
        `CHK(rd, 32'h00000081)
        drv_en[1] <= 1'b0;
        upd();
        tk(3);
        `CHK(multi_pin_out[1], 1'b1)
        wr(mpm_pkg::IDX_FUNC_FIRST + 14'h2, 8'h01);
        drv <= 7'h04;
        upd();
        tk(3);
        cnt = 0;
        drv <= 7'h00;
        repeat (8) begin
            @(posedge mclk);
            cnt += int'(ctrl_out.config_update);
        end
        `CHK(cnt, 1)
        $display("control test done");
        sys_rst <= 1'b1;
        tk(6);
        sys_rst <= 1'b0;
        tk(2);
        `CHK(multi_pin_oe, 7'h00)
        `CHK(ctrl_out, 4'h0)
        $display("reset test done");
        results();
    end
endmodule // tb_top
`default_nettype wire
